//--- rtl/lcd_pps_pkg.sv
package lcd_pps_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_PHASE_PRESCALE = 4'h0;
  localparam logic [3:0] ADDR_DRIVER_CTRL = 4'h4;
  localparam logic [3:0] ADDR_SEG_PATTERN = 4'h8;

  // ****************************************
  // phase/prescale and driver control fields
  // ****************************************
  localparam int BIAS_BIT = 6;
  localparam int ACTIVE_BIT = 5;
  localparam int WALLOW_BIT = 4;
  localparam int PRESCALE_LSB = 0;
  localparam int PRESCALE_W = 4;
  localparam int MUX_LSB = 0;
  localparam int MUX_W = 2;
  localparam int ENABLE_BIT = 7;

  localparam logic [7:0] PHASE_PRESCALE_RST = 8'h00;
  localparam logic [7:0] DRIVER_CTRL_RST = 8'h00;
  localparam logic [7:0] SEG_PATTERN_RST = 8'h00;
  localparam logic [1:0] MUX_QUAD = 2'h3;

  // ****************************************
  // frame timing
  // ****************************************
  localparam logic [3:0] FRAME_TICKS = 4'hF;

endpackage

//--- rtl/lcd_clock_prescaler.sv
`timescale 1ns/1ps
module lcd_clock_prescaler
  import lcd_pps_pkg::*;
#(
  parameter int W = PRESCALE_W
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [W-1:0] ratio_sel_i,
  output logic tick_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } pre_s;

  pre_s st_q;
  pre_s st_d;

  // one tick per (ratio_sel + 1) clocks
  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run_i)
    begin
      st_d.cnt = '0;
    end
    else if (st_q.cnt >= ratio_sel_i)
    begin
      st_d.cnt = '0;
      st_d.tick = 1'b1; // R5
    end
    else
    begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;

endmodule

//--- rtl/lcd_phase_prescale_status.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: with four-phase multiplex the bias bit selects one-third bias; software keeps it zero.
// R2: the bias restriction holds when the multiplex select field equals binary 11.
// R3: driver-active flag reads one while the driver runs, zero while idle.
// R4: write-allow flag reads one only when segment pattern writes are permitted.
// R5: prescaler field divides the LCD clock by field value plus one.
// R6: unimplemented bits read as zero.
// R7: software writes to the two status flag positions have no effect.
module lcd_phase_prescale_status
  import lcd_pps_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic lcd_tick_o,
  output logic driver_active_o,
  output logic bias_half_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic bias;
    logic [3:0] prescale;
    logic enable;
    logic [1:0] mux;
    logic active;
    logic wallow;
    logic [3:0] frame_cnt;
    logic [7:0] seg_pattern;
    logic [31:0] rdata;
    logic ack;
    logic tick;
    logic bias_half;
  } st_s;

  st_s st_q;
  st_s st_d;
  logic pre_tick;

  function automatic logic [7:0] pps_read(input st_s s);
    logic [7:0] v;
    v = 8'h00; // R6
    v[BIAS_BIT] = s.bias;
    v[ACTIVE_BIT] = s.active; // R3
    v[WALLOW_BIT] = s.wallow; // R4
    v[PRESCALE_LSB +: PRESCALE_W] = s.prescale;
    return v;
  endfunction

  lcd_clock_prescaler #(
    .W(PRESCALE_W)
  ) u_pre (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(st_q.active),
    .ratio_sel_i(st_q.prescale),
    .tick_o(pre_tick)
  );

  // ****************************************
  // bus slave and status
  // ****************************************
  logic req;
  logic wr_hit;
  assign req = (avs_read || avs_write) && !st_q.ack;
  assign wr_hit = avs_write && !st_q.ack;

  always_comb
  begin
    st_d = st_q;
    st_d.ack = req;
    st_d.tick = pre_tick;
    st_d.rdata = 32'h0000_0000;
    if (avs_read && !st_q.ack)
    begin
      case (avs_address)
        ADDR_PHASE_PRESCALE: st_d.rdata = {24'h000000, pps_read(st_q)};
        ADDR_DRIVER_CTRL:
        begin
          st_d.rdata[ENABLE_BIT] = st_q.enable;
          st_d.rdata[MUX_LSB +: MUX_W] = st_q.mux;
        end
        ADDR_SEG_PATTERN: st_d.rdata[7:0] = st_q.seg_pattern;
        default: st_d.rdata = 32'h0000_0000; // R6
      endcase
    end
    if (wr_hit && avs_byteenable[0])
    begin
      case (avs_address)
        ADDR_PHASE_PRESCALE:
        begin
          // status bits are not taken from the bus
          st_d.bias = avs_writedata[BIAS_BIT]; // R7
          st_d.prescale = avs_writedata[PRESCALE_LSB +: PRESCALE_W]; // R5
        end
        ADDR_DRIVER_CTRL:
        begin
          st_d.enable = avs_writedata[ENABLE_BIT];
          st_d.mux = avs_writedata[MUX_LSB +: MUX_W];
        end
        ADDR_SEG_PATTERN:
        begin
          if (st_q.wallow) // R4
          begin
            st_d.seg_pattern = avs_writedata[7:0];
          end
        end
        default: st_d.seg_pattern = st_q.seg_pattern;
      endcase
    end
    // driver follows enable; write window opens at frame end
    st_d.active = st_q.enable; // R3
    if (!st_q.active)
    begin
      st_d.frame_cnt = 4'h0;
      st_d.wallow = 1'b1; // R4
    end
    else if (pre_tick)
    begin
      st_d.frame_cnt = st_q.frame_cnt + 4'h1;
      st_d.wallow = (st_q.frame_cnt == FRAME_TICKS); // R4
    end
    // quad multiplex ignores the bias bit and forces one-third
    st_d.bias_half = st_q.bias && (st_q.mux != MUX_QUAD); // R1 R2
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = !st_q.ack;
  assign lcd_tick_o = st_q.tick;
  assign driver_active_o = st_q.active;
  assign bias_half_o = st_q.bias_half;

  // ****************************************
  // assertions
  // ****************************************
  logic rd_hit;
  logic rd_pps;
  logic rd_ctrl;
  logic rd_seg;
  logic wr_lane;
  logic wr_pps;
  logic wr_ctrl;
  logic wr_seg;
  logic addr_mapped;
  assign rd_hit = avs_read && !st_q.ack;
  assign rd_pps = rd_hit && avs_address == ADDR_PHASE_PRESCALE;
  assign rd_ctrl = rd_hit && avs_address == ADDR_DRIVER_CTRL;
  assign rd_seg = rd_hit && avs_address == ADDR_SEG_PATTERN;
  assign wr_lane = wr_hit && avs_byteenable[0];
  assign wr_pps = wr_lane && avs_address == ADDR_PHASE_PRESCALE;
  assign wr_ctrl = wr_lane && avs_address == ADDR_DRIVER_CTRL;
  assign wr_seg = wr_lane && avs_address == ADDR_SEG_PATTERN;
  assign addr_mapped = avs_address == ADDR_PHASE_PRESCALE || avs_address == ADDR_DRIVER_CTRL
    || avs_address == ADDR_SEG_PATTERN;

  a_status_active: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R3
    ##1 st_q.active == $past(st_q.enable))
    else $error("active flag does not follow enable");
  a_wallow_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    !st_q.active |=> st_q.wallow)
    else $error("write allow low while idle");
  a_seg_blocked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    (wr_hit && avs_address == ADDR_SEG_PATTERN && !st_q.wallow) |=> $stable(st_q.seg_pattern))
    else $error("segment write taken while blocked");
  // a bus write may move the ratio mid-count, so it cancels the attempt
  a_tick_ratio: assert property (@(posedge core_clk_i) disable iff (!rst_n_i || wr_hit) // R5
    (pre_tick && st_q.active && st_q.enable && $stable(st_q.prescale)
      && st_q.prescale == 4'h3) |=> !pre_tick [*3] ##1 pre_tick)
    else $error("prescale ratio wrong");
  a_tick_full: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
    (st_q.active && st_q.prescale == 4'h0) |=> pre_tick)
    else $error("ratio one does not tick every cycle");
  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    (avs_read && !st_q.ack && avs_address == ADDR_PHASE_PRESCALE) |=> avs_readdata[31:7] == 0)
    else $error("reserved bits not zero");
  a_status_ro: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R7
    (wr_hit && avs_address == ADDR_PHASE_PRESCALE && st_q.active == st_q.enable)
      |=> st_q.active == $past(st_q.active))
    else $error("bus write changed active flag");
  a_quad_bias: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
    (st_q.mux == MUX_QUAD) |=> !bias_half_o)
    else $error("half bias in quad multiplex");
  a_bus_ack: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (req) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  a_ack_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  a_ack_stand: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer stands longer than one cycle");

  // ****************************************
  // register read checks
  // ****************************************
  a_read_bias: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_pps |=> avs_readdata[BIAS_BIT] == $past(st_q.bias))
    else $error("bias bit read wrong");
  a_read_active: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R3
    rd_pps |=> avs_readdata[ACTIVE_BIT] == $past(st_q.active))
    else $error("active flag read wrong");
  a_read_wallow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    rd_pps |=> avs_readdata[WALLOW_BIT] == $past(st_q.wallow))
    else $error("write allow flag read wrong");
  a_read_prescale: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
    rd_pps |=> avs_readdata[PRESCALE_LSB +: PRESCALE_W] == $past(st_q.prescale))
    else $error("prescale field read wrong");
  a_read_top: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    rd_pps |=> !avs_readdata[7])
    else $error("unimplemented bit seven not zero");
  a_ctrl_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_ctrl |=> avs_readdata[ENABLE_BIT] == $past(st_q.enable))
    else $error("enable bit read wrong");
  a_ctrl_mux: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R2
    rd_ctrl |=> avs_readdata[MUX_LSB +: MUX_W] == $past(st_q.mux))
    else $error("multiplex select read wrong");
  a_ctrl_reserved: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    rd_ctrl |=> avs_readdata[6:2] == 5'h00 && avs_readdata[31:8] == 24'h000000)
    else $error("control reserved bits not zero");
  a_seg_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    rd_seg |=> avs_readdata[7:0] == $past(st_q.seg_pattern))
    else $error("segment pattern read wrong");
  a_seg_upper: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    rd_seg |=> avs_readdata[31:8] == 24'h000000)
    else $error("segment upper bits not zero");
  a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    (rd_hit && !addr_mapped) |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !rd_hit |=> avs_readdata == 32'h0000_0000)
    else $error("read data without read");

  // ****************************************
  // register write checks
  // ****************************************
  a_prescale_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
    wr_pps |=> {28'h0, st_q.prescale} == ($past(avs_writedata) & 32'h0000_000F))
    else $error("prescale write lost");
  a_bias_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_pps |=> {25'h0, st_q.bias, 6'h0} == ($past(avs_writedata) & 32'h0000_0040))
    else $error("bias write lost");
  a_enable_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctrl |=> {24'h0, st_q.enable, 7'h0} == ($past(avs_writedata) & 32'h0000_0080))
    else $error("enable write lost");
  a_mux_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_ctrl |=> {30'h0, st_q.mux} == ($past(avs_writedata) & 32'h0000_0003))
    else $error("multiplex write lost");
  a_seg_taken: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    (wr_seg && st_q.wallow) |=> {24'h0, st_q.seg_pattern} == ($past(avs_writedata) & 32'h0000_00FF))
    else $error("allowed segment write lost");
  a_seg_other: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    !wr_seg |=> $stable(st_q.seg_pattern))
    else $error("segment pattern changed without write");
  a_unmapped_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R6
    (wr_hit && !addr_mapped) |=> $stable(st_q.prescale) && $stable(st_q.bias)
      && $stable(st_q.enable) && $stable(st_q.mux))
    else $error("unmapped write changed a register");
  a_cfg_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !wr_hit |=> $stable(st_q.prescale) && $stable(st_q.bias))
    else $error("settings changed without write");

  // ****************************************
  // status and prescaler checks
  // ****************************************
  a_wallow_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R7
    (st_q.active && !pre_tick) |=> $stable(st_q.wallow))
    else $error("write allow moved between ticks");
  a_wallow_tick: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    (st_q.active && pre_tick && st_q.frame_cnt != FRAME_TICKS) |=> !st_q.wallow)
    else $error("write allow open inside frame");
  a_wallow_end: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    (st_q.active && pre_tick && st_q.frame_cnt == FRAME_TICKS) |=> st_q.wallow)
    else $error("write allow closed at frame end");
  a_frame_step: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    (st_q.active && pre_tick) |=> st_q.frame_cnt == $past(st_q.frame_cnt) + 4'h1)
    else $error("frame counter did not step");
  a_frame_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R4
    !st_q.active |=> st_q.frame_cnt == 4'h0)
    else $error("frame counter runs while idle");
  a_tick_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
    !st_q.active |=> !pre_tick)
    else $error("prescaler ticks while idle");
  a_tick_pin: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
    pre_tick |=> lcd_tick_o)
    else $error("tick not passed to pin");
  a_tick_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R5
    !pre_tick |=> !lcd_tick_o)
    else $error("tick pin without prescaler tick");
  a_bias_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1
    (st_q.mux != MUX_QUAD) |=> bias_half_o == $past(st_q.bias))
    else $error("bias pin does not follow bias bit");
  a_bias_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // R1
    !st_q.bias |=> !bias_half_o)
    else $error("half bias with bias bit clear");

  c_run: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(st_q.active));
  c_window: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    st_q.active && $rose(st_q.wallow));
  c_seg_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_hit && avs_address == ADDR_SEG_PATTERN && st_q.wallow);
  c_slow: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pre_tick && st_q.prescale == 4'hF);

endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  import lcd_pps_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic lcd_tick_o;
  logic driver_active_o;
  logic bias_half_o;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] seen;

  lcd_phase_prescale_status dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lcd_tick_o(lcd_tick_o), .driver_active_o(driver_active_o), .bias_half_o(bias_half_o));

  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ****************************
  // bus tasks and checks
  // ****************************
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // only the cycle timeout ends a wait for the answer
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do
    begin
      @(posedge core_clk_i);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // poll the status until the write-allow flag reads v
  task automatic wait_wallow(input logic v);
    do
    begin
      bus(1'b0, ADDR_PHASE_PRESCALE, 32'h0);
    end
    while (rd[WALLOW_BIT] !== v);
  endtask

  // cycles between two prescaler ticks
  task automatic gap(input int p);
    int n;
    n = 0;
    do @(posedge core_clk_i); while (lcd_tick_o !== 1'b1 && n++ < 100);
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (lcd_tick_o !== 1'b1 && n < 100);
    check("tick_gap", n, p + 1);
  endtask

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rdchk("reset_status", ADDR_PHASE_PRESCALE, 32'h10);
    bus(1'b1, ADDR_SEG_PATTERN, 32'hA5);
    rdchk("seg_idle_write", ADDR_SEG_PATTERN, 32'hA5);
    bus(1'b1, ADDR_PHASE_PRESCALE, 32'hFF);
    rdchk("status_write", ADDR_PHASE_PRESCALE, 32'h5F);
    check("bias_mux0", {31'h0, bias_half_o}, 32'h1);
    bus(1'b1, ADDR_DRIVER_CTRL, 32'h3);
    rdchk("ctrl_readback", ADDR_DRIVER_CTRL, 32'h3);
    repeat (2) @(posedge core_clk_i);
    check("bias_mux3", {31'h0, bias_half_o}, 32'h0);
    rdchk("unmapped", 4'hC, 32'h0);
    bus(1'b1, 4'hC, 32'hFF);
    rdchk("unmapped_write", ADDR_PHASE_PRESCALE, 32'h5F);
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, ADDR_PHASE_PRESCALE, (k == 0) ? 32'hF : (k == 1) ? 32'h3 : 32'h0);
      bus(1'b1, ADDR_DRIVER_CTRL, 32'h80);
      gap((k == 0) ? 15 : (k == 1) ? 3 : 0);
      bus(1'b0, ADDR_PHASE_PRESCALE, 32'h0);
      check("active_prescale", rd & 32'h0000_000F, (k == 0) ? 32'hF : (k == 1) ? 32'h3 : 32'h0);
      check("active_bits", rd & 32'hFFFFFFEF, (k == 0) ? 32'h2F : (k == 1) ? 32'h23 : 32'h20);
      check("active_pin", {31'h0, driver_active_o}, 32'h1);
    end
    // slow frame: the write window is short, so writes are timed off its edges
    bus(1'b1, ADDR_PHASE_PRESCALE, 32'hF);
    wait_wallow(1'b1);
    wait_wallow(1'b0);
    bus(1'b1, ADDR_SEG_PATTERN, 32'h3C);
    rdchk("seg_blocked", ADDR_SEG_PATTERN, 32'hA5);
    wait_wallow(1'b1);
    bus(1'b1, ADDR_SEG_PATTERN, 32'h5A);
    rdchk("seg_open", ADDR_SEG_PATTERN, 32'h5A);
    bus(1'b1, ADDR_PHASE_PRESCALE, 32'h0);
    seen = 2'b00;
    for (int j = 0; j < 40; j++)
    begin
      bus(1'b0, ADDR_PHASE_PRESCALE, 32'h0);
      seen[rd[WALLOW_BIT]] = 1'b1;
    end
    check("wallow_toggles", {30'h0, seen}, 32'h3);
    bus(1'b1, ADDR_DRIVER_CTRL, 32'h0);
    repeat (3) @(posedge core_clk_i);
    rdchk("idle_status", ADDR_PHASE_PRESCALE, 32'h10);
    check("idle_pin", {31'h0, driver_active_o}, 32'h0);
    end_of_test();
  end
endmodule
